// *** hdl/btlsq_pkg.sv ***
// btlsq_pkg: constants shared by the trip latch sequencer files.
// assumes a single 50 MHz clock; all delays count a 1 ms tick.
package btlsq_pkg;
  // clock and time base
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_PER_S = 1000;
  localparam int S_PER_MIN = 60;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int DIV_W = 17;

  // delays, each in its own unit, then in ms ticks
  localparam int T_RESET_MIN = 3;
  localparam int T_UNMANNED_MIN = 30;
  localparam int T_STRETCH_MS = 30;
  localparam int T_HOLD_S = 1;
  localparam int T_FLASH_MS = 500;
  localparam int T_RESET_MS = T_RESET_MIN * S_PER_MIN * MS_PER_S;
  localparam int T_UNMANNED_MS = T_UNMANNED_MIN * S_PER_MIN * MS_PER_S;
  localparam int T_HOLD_MS = T_HOLD_S * MS_PER_S;
  localparam int TW = 22;

  // pin vector positions after the synchroniser
  localparam int PIN_PULSE = 0;
  localparam int PIN_RESET = 1;
  localparam int PIN_TEST = 2;
  localparam int PIN_BYPASS = 3;
  localparam int PIN_POWER = 4;
  localparam int NPIN = 5;

  // apb register map
  localparam int AW = 12;
  localparam int DW = 32;
  localparam logic [AW-1:0] ADDR_CTRL = 12'h000;
  localparam logic [AW-1:0] ADDR_STAT = 12'h004;
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_UNMANNED = 1;
  localparam logic [DW-1:0] CTRL_RESET = 32'h0000_0001;
  localparam int STAT_LATCH = 0;
  localparam int STAT_LAMP = 1;
  localparam int STAT_CONTACT = 2;
  localparam int STAT_ELAPSED = 3;
  localparam int STAT_HOLD = 4;
  localparam int STAT_BYPASS = 5;
  localparam int STAT_DRIVE = 6;
  localparam int STAT_POWER = 7;
endpackage : btlsq_pkg

// *** hdl/btlsq_tmr_if.sv ***
// btlsq_tmr_if: run, tick and target in, elapsed out, for one timer.
// assumes the owner drives tick as a one-cycle 1 ms pulse.
`timescale 1ns/1ps
`default_nettype none
interface btlsq_tmr_if;
  logic run;
  logic tick;
  logic [btlsq_pkg::TW-1:0] target;
  logic elapsed;
  modport owner(output run, output tick, output target, input elapsed);
  modport timer(input run, input tick, input target, output elapsed);
endinterface : btlsq_tmr_if
`default_nettype wire

// *** hdl/btlsq_sync.sv ***
// btlsq_sync: two-flop synchroniser for a vector of panel pins.
// assumes each bit is a slow level; no bus coherency between bits.
`timescale 1ns/1ps
`default_nettype none
module btlsq_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // pins and synchronised copy
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } btlsq_sync_st_t;

  btlsq_sync_st_t st_reg, st_next;

  // meta is read only by the second stage
  always_comb begin
    st_next = st_reg;
    st_next.meta = d;
    st_next.q = st_reg.meta;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.q;
endmodule : btlsq_sync
`default_nettype wire

// *** hdl/btlsq_timer.sv ***
// btlsq_timer: counts 1 ms ticks while run is high, clears when low.
// assumes target fits in TW bits; elapsed is registered.
`timescale 1ns/1ps
`default_nettype none
module btlsq_timer (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // owner side
  btlsq_tmr_if.timer t
);
  import btlsq_pkg::*;

  typedef struct packed {
    logic [TW-1:0] cnt;
    logic elapsed;
  } btlsq_tmr_st_t;

  btlsq_tmr_st_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (!t.run) begin
      st_next.cnt = '0;
    end else if (t.tick && (st_reg.cnt < t.target)) begin
      st_next.cnt = TW'(st_reg.cnt + 1'b1);
    end
    st_next.elapsed = t.run && (st_next.cnt >= t.target);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign t.elapsed = st_reg.elapsed;
endmodule : btlsq_timer
`default_nettype wire

// *** hdl/btlsq_top.sv ***
// btlsq_top: trip latch sequencer with apb control and status.
// assumes panel pins and the detector pulse are asynchronous levels;
// the apb master runs on the same clock.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - power-up starts tripped: lamp lit, reset delay timing, latch off
// - reset delay reports elapsed three minutes after it starts
// - auto strap plus elapsed delay and active drive energizes latch
// - energized latch holds itself after the delay timer releases
// - energized latch puts lamp out and closes output continuity
// - drive inactive drops latch, opens output unless hold or bypass
// - trip lights lamp steadily and restarts the reset delay
// - after trip latch stays off when drive returns until delay allows
// - after trip with auto strap set latch re-arms automatically once delay elapses
// - bypass key in manual lights bypass lamp, forces continuity
// - test switch with latch energized energizes the test hold coil
// - active test hold forces continuity and keeps latch supply
// - test switch triggers stimulus only once test hold is active
// - each detection drops drive for 30 ms, then latch re-energizes
// - latch dropping during test removes the test hold coil drive
// - test hold outputs stay one second after coil drive removed
// - stimulus and flash cycle repeats while test switch is held
// - power loss opens output continuity and keeps it open
// - manual reset switch re-arms only after the delay has elapsed
// - unmanned option with auto strap re-arms automatically after thirty minutes
module btlsq_top #(
  parameter int CLK_HZ = btlsq_pkg::CLK_HZ,
  parameter int CYC_PER_MS = CLK_HZ / btlsq_pkg::MS_PER_S,
  parameter int RESET_MS = btlsq_pkg::T_RESET_MS,
  parameter int UNMANNED_MS = btlsq_pkg::T_UNMANNED_MS
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // apb slave
  input wire logic [btlsq_pkg::AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [btlsq_pkg::DW-1:0] pwdata,
  output logic [btlsq_pkg::DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // detector and panel pins
  input wire logic det_pulse,
  input wire logic reset_sw,
  input wire logic test_sw,
  input wire logic bypass_key,
  input wire logic power_ok,
  // contact, lamps and stimulus
  output logic output_contact,
  output logic trip_lamp,
  output logic bypassed_lamp,
  output logic test_stimulus
);
  import btlsq_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic tick;
    logic auto_rst;
    logic unmanned;
    logic ack;
    logic err;
    logic [DW-1:0] rdata;
    logic output_latch;
    logic hold_coil;
    logic hold_armed;
    logic stretch;
    logic pulse_prev;
    logic stim;
    logic contact;
    logic lamp;
    logic byp_lamp;
  } btlsq_st_t;

  btlsq_st_t st_reg, st_next;

  // address decode: bit 0 ctrl, bit 1 status
  function automatic logic [1:0] btlsq_dec(input logic [AW-1:0] a);
    btlsq_dec = {a == ADDR_STAT, a == ADDR_CTRL};
  endfunction : btlsq_dec

  // synchronised pins
  logic [NPIN-1:0] pins_s;
  logic pulse_s, rsw_s, tst_s, byp_s, pwr_s;

  btlsq_sync #(.W(NPIN)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d({power_ok, bypass_key, test_sw, reset_sw, det_pulse}),
    .q(pins_s)
  );

  assign pulse_s = pins_s[PIN_PULSE];
  assign rsw_s = pins_s[PIN_RESET];
  assign tst_s = pins_s[PIN_TEST];
  assign byp_s = pins_s[PIN_BYPASS];
  assign pwr_s = pins_s[PIN_POWER];

  // timers
  btlsq_tmr_if rst_if ();
  btlsq_tmr_if str_if ();
  btlsq_tmr_if hld_if ();
  btlsq_tmr_if fl_if ();

  btlsq_timer u_rst_tmr (.clock(clock), .nrst(nrst), .t(rst_if));
  btlsq_timer u_str_tmr (.clock(clock), .nrst(nrst), .t(str_if));
  btlsq_timer u_hld_tmr (.clock(clock), .nrst(nrst), .t(hld_if));
  btlsq_timer u_fl_tmr (.clock(clock), .nrst(nrst), .t(fl_if));

  // combined terms
  logic detection_drive;
  logic test_hold;
  logic arm_ok;
  logic pulse_edge;
  logic setup;
  logic access;
  logic [1:0] sel;
  logic [DW-1:0] stat_word;
  logic [DW-1:0] ctrl_word;

  // stretched pulse holds the drive off; drive is active at reset
  assign detection_drive = !st_reg.stretch;
  assign test_hold = st_reg.hold_coil | st_reg.hold_armed;
  // manual reset still needs the delay to be over
  assign arm_ok = rst_if.elapsed & (st_reg.auto_rst | rsw_s);
  assign pulse_edge = pulse_s & !st_reg.pulse_prev;
  assign setup = psel & !penable;
  assign access = psel & penable & st_reg.ack;
  assign sel = btlsq_dec(paddr);

  // reset delay runs whenever the latch is out and power is on
  assign rst_if.tick = st_reg.tick;
  assign rst_if.run = !st_reg.output_latch & pwr_s;
  assign rst_if.target = st_reg.unmanned ? TW'(UNMANNED_MS)
                                         : TW'(RESET_MS);
  assign str_if.tick = st_reg.tick;
  assign str_if.run = st_reg.stretch;
  assign str_if.target = TW'(T_STRETCH_MS);
  assign hld_if.tick = st_reg.tick;
  assign hld_if.run = st_reg.hold_armed & !st_reg.hold_coil;
  assign hld_if.target = TW'(T_HOLD_MS);
  // flash period restarts itself the cycle after it elapses
  assign fl_if.tick = st_reg.tick;
  assign fl_if.run = tst_s & test_hold & !fl_if.elapsed;
  assign fl_if.target = TW'(T_FLASH_MS);

  always_comb begin
    stat_word = '0;
    stat_word[STAT_LATCH] = st_reg.output_latch;
    stat_word[STAT_LAMP] = st_reg.lamp;
    stat_word[STAT_CONTACT] = st_reg.contact;
    stat_word[STAT_ELAPSED] = rst_if.elapsed;
    stat_word[STAT_HOLD] = test_hold;
    stat_word[STAT_BYPASS] = byp_s;
    stat_word[STAT_DRIVE] = detection_drive;
    stat_word[STAT_POWER] = pwr_s;
    ctrl_word = '0;
    ctrl_word[CTRL_AUTO] = st_reg.auto_rst;
    ctrl_word[CTRL_UNMANNED] = st_reg.unmanned;
  end

  always_comb begin
    st_next = st_reg;

    // 1 ms tick from the system clock
    if (st_reg.div == DIV_W'(CYC_PER_MS - 1)) begin
      st_next.div = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.div = DIV_W'(st_reg.div + 1'b1);
      st_next.tick = 1'b0;
    end

    // apb: answer in the first access cycle, no wait states
    st_next.ack = setup;
    st_next.err = setup & (sel == 2'b00);
    st_next.rdata = '0;
    if (setup && !pwrite) begin
      if (sel[0]) begin
        st_next.rdata = ctrl_word;
      end else if (sel[1]) begin
        st_next.rdata = stat_word;
      end
    end
    if (access && pwrite && sel[0]) begin
      st_next.auto_rst = pwdata[CTRL_AUTO];
      st_next.unmanned = pwdata[CTRL_UNMANNED];
    end

    // pulse stretcher; retriggers during a stretch are ignored
    st_next.pulse_prev = pulse_s;
    if (pulse_edge && !st_reg.stretch) begin
      st_next.stretch = 1'b1;
    end else if (str_if.elapsed) begin
      st_next.stretch = 1'b0;
    end

    // latch needs drive; holds itself, or via test supply, or re-arms
    st_next.output_latch = pwr_s & detection_drive
      & (st_reg.output_latch | test_hold | arm_ok);

    // test hold coil only through the energized latch
    st_next.hold_coil = tst_s & st_reg.output_latch & pwr_s;

    // release delay; a new coil drive wins over the timeout
    if (st_reg.hold_coil) begin
      st_next.hold_armed = 1'b1;
    end else if (hld_if.elapsed) begin
      st_next.hold_armed = 1'b0;
    end

    // stimulus only with the hold already in place
    st_next.stim = fl_if.elapsed & test_hold;

    // registered pin drive; lamps and contact need operating power
    st_next.contact = pwr_s & (st_next.output_latch | byp_s
      | st_next.hold_coil | st_next.hold_armed);
    st_next.lamp = pwr_s & !st_next.output_latch;
    st_next.byp_lamp = pwr_s & byp_s;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.auto_rst <= CTRL_RESET[CTRL_AUTO];
      st_reg.unmanned <= CTRL_RESET[CTRL_UNMANNED];
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign pready = st_reg.ack;
  assign pslverr = st_reg.err;
  assign output_contact = st_reg.contact;
  assign trip_lamp = st_reg.lamp;
  assign bypassed_lamp = st_reg.byp_lamp;
  assign test_stimulus = st_reg.stim;

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  a_power_up_trip: assert property (
    $rose(pwr_s) && !st_reg.output_latch |=> trip_lamp && rst_if.run)
    else $error("power-up did not start tripped");

  a_auto_rearm: assert property (
    pwr_s && rst_if.elapsed && st_reg.auto_rst && detection_drive
    |=> st_reg.output_latch)
    else $error("latch not re-armed after elapsed delay");

  a_latch_hold: assert property (
    st_reg.output_latch && pwr_s && detection_drive
    |=> st_reg.output_latch)
    else $error("energized latch failed to hold");

  // lamp and contact are registered from the next latch state, same edge
  a_lamp_contact: assert property (
    st_reg.output_latch |-> !trip_lamp && output_contact)
    else $error("lamp or contact wrong with latch energized");

  a_drive_drop: assert property (
    !detection_drive |=> !st_reg.output_latch)
    else $error("latch held without detection drive");

  a_no_early_arm: assert property (
    !st_reg.output_latch && !rst_if.elapsed && !test_hold
    |=> !st_reg.output_latch)
    else $error("latch re-armed before the delay");

  a_bypass_close: assert property (
    byp_s && pwr_s |=> output_contact && bypassed_lamp)
    else $error("bypass did not force continuity");

  a_coil_via_latch: assert property (
    $rose(st_reg.hold_coil) |-> $past(st_reg.output_latch))
    else $error("test hold coil energized without latch");

  a_hold_forces: assert property (
    test_hold && $past(pwr_s) |-> output_contact)
    else $error("test hold did not keep continuity");

  a_stim_after_hold: assert property (
    test_stimulus |-> $past(test_hold))
    else $error("stimulus before test hold");

  a_hold_stays: assert property (
    $fell(st_reg.hold_coil) |-> st_reg.hold_armed [*8])
    else $error("test hold released too early");

  a_power_loss: assert property (
    !pwr_s |=> !output_contact && !st_reg.output_latch)
    else $error("continuity closed without power");

  c_auto_rearm: cover property ($rose(st_reg.output_latch));
  c_stimulus: cover property (test_stimulus);
  c_hold_timeout: cover property ($fell(st_reg.hold_armed));
  c_bypass_trip: cover property (byp_s && !st_reg.output_latch
    ##1 output_contact);
endmodule : btlsq_top
`default_nettype wire

// *** testbench/btlsq_far_model.sv ***
// btlsq_far_model: detector head and neon test loop for the sequencer.
// assumes stimulus is a one-cycle pulse on the bench clock.
`timescale 1ns/1ps
`default_nettype none
module btlsq_far_model (
  // clock
  input wire logic clock,
  // test stimulus and bench trip request
  input wire logic stimulus,
  input wire logic trip_req,
  // raw detector pulse
  output logic det_pulse
);
  logic [3:0] dly;
  initial dly = 4'h0;
  initial det_pulse = 1'b0;
  // neon needs charge time, so the flash lags the stimulus
  always @(posedge clock) begin
    dly <= {dly[2:0], stimulus};
    det_pulse <= dly[3] | trip_req;
  end
endmodule : btlsq_far_model
`default_nettype wire

// *** testbench/tb.sv ***
// tb: apb and panel sequences for the trip latch sequencer.
// assumes short delay parameters; far side is btlsq_far_model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import btlsq_pkg::*;
  localparam int CPM = 4;
  localparam int RMS = 20;
  localparam int UMS = 40;
  // status right after power-up: lamp lit, drive active, power present
  localparam logic [DW-1:0] STAT_TRIPPED = (32'h1 << STAT_LAMP)
    | (32'h1 << STAT_DRIVE) | (32'h1 << STAT_POWER);
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [DW-1:0] pwdata = '0;
  logic [DW-1:0] prdata;
  logic pready;
  logic pslverr;
  logic det_pulse;
  logic reset_sw = 1'b0;
  logic test_sw = 1'b0;
  logic bypass_key = 1'b0;
  logic power_ok = 1'b1;
  logic output_contact;
  logic trip_lamp;
  logic bypassed_lamp;
  logic test_stimulus;
  logic trip_req = 1'b0;
  logic in_test = 1'b0;
  logic [DW-1:0] rd;
  logic er;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int drops = 0;
  int stims = 0;
  int lit = 0;

  always #10 clock = ~clock;

  btlsq_top #(.CYC_PER_MS(CPM), .RESET_MS(RMS), .UNMANNED_MS(UMS))
  btlsq_top_inst (.clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .det_pulse(det_pulse),
    .reset_sw(reset_sw), .test_sw(test_sw), .bypass_key(bypass_key),
    .power_ok(power_ok), .output_contact(output_contact),
    .trip_lamp(trip_lamp), .bypassed_lamp(bypassed_lamp),
    .test_stimulus(test_stimulus));

  btlsq_far_model btlsq_far_model_inst (.clock(clock),
    .stimulus(test_stimulus), .trip_req(trip_req), .det_pulse(det_pulse));

  task give_verdict;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task chk_pin(input logic a, input logic e);
    comparisons++;
    if (a !== e) begin
      failures++;
      $display("unexpected at %0t: got %0h want %0h", $time, a, e);
    end
  endtask : chk_pin

  task chk_word(input logic [DW-1:0] a, input logic [DW-1:0] e);
    comparisons++;
    if (a !== e) begin
      failures++;
      $display("unexpected at %0t: got %0h want %0h", $time, a, e);
    end
  endtask : chk_word

  // entered just after a rising edge; answer taken at the edge it stands
  task apb(input logic [AW-1:0] a, input logic w, input logic [DW-1:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never re-drives psel at once
    @(posedge clock);
  endtask : apb

  task rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e,
    input logic ee);
    apb(a, 1'b0, '0);
    chk_word(rd, e);
    chk_pin(er, ee);
  endtask : rd_chk

  task idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle

  task see(input logic c, input logic l, input logic b);
    @(negedge clock);
    chk_pin(output_contact, c);
    chk_pin(trip_lamp, l);
    chk_pin(bypassed_lamp, b);
    @(posedge clock);
  endtask : see

  task wait_contact(input logic v, input int max);
    int n;
    n = 0;
    @(negedge clock);
    while (output_contact !== v && n < max) begin
      @(negedge clock);
      n++;
    end
    chk_pin(output_contact, v);
    @(posedge clock);
  endtask : wait_contact

  task trip;
    trip_req <= 1'b1;
    idle(2);
    trip_req <= 1'b0;
    wait_contact(1'b0, 10);
  endtask : trip

  // a single contact drop during test means the hold failed
  always @(negedge clock) begin
    if (in_test) begin
      if (output_contact !== 1'b1) drops++;
      if (test_stimulus === 1'b1) stims++;
      if (trip_lamp === 1'b1) lit++;
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles > 40000) begin
      failures++;
      give_verdict;
    end
  end

  initial begin
    idle(16);
    nrst <= 1'b1;
    idle(1);
    rd_chk(ADDR_CTRL, CTRL_RESET, 1'b0);
    rd_chk(12'h008, 32'h0000_0000, 1'b1);
    apb(ADDR_STAT, 1'b1, 32'hFFFF_FFFF);
    rd_chk(ADDR_STAT, STAT_TRIPPED, 1'b0);
    chk_pin(rd[STAT_LATCH], 1'b0);
    see(1'b0, 1'b1, 1'b0);
    idle(50);
    see(1'b0, 1'b1, 1'b0);
    wait_contact(1'b1, 60);
    see(1'b1, 1'b0, 1'b0);
    idle(200);
    see(1'b1, 1'b0, 1'b0);
    trip();
    see(1'b0, 1'b1, 1'b0);
    wait_contact(1'b1, RMS * CPM + 60);
    apb(ADDR_CTRL, 1'b1, 32'h0000_0003);
    trip();
    idle(140);
    see(1'b0, 1'b1, 1'b0);
    wait_contact(1'b1, 60);
    apb(ADDR_CTRL, 1'b1, 32'h0000_0000);
    trip();
    idle(300);
    see(1'b0, 1'b1, 1'b0);
    reset_sw <= 1'b1;
    wait_contact(1'b1, 10);
    reset_sw <= 1'b0;
    apb(ADDR_CTRL, 1'b1, CTRL_RESET);
    trip();
    bypass_key <= 1'b1;
    wait_contact(1'b1, 10);
    see(1'b1, 1'b1, 1'b1);
    bypass_key <= 1'b0;
    idle(300);
    see(1'b1, 1'b0, 1'b0);
    in_test <= 1'b1;
    test_sw <= 1'b1;
    idle(20);
    apb(ADDR_STAT, 1'b0, '0);
    chk_pin(rd[STAT_HOLD], 1'b1);
    idle(7000);
    test_sw <= 1'b0;
    idle(5000);
    in_test <= 1'b0;
    chk_word(drops, 0);
    chk_pin(stims > 2, 1'b1);
    chk_pin(lit > 0, 1'b1);
    apb(ADDR_STAT, 1'b0, '0);
    chk_pin(rd[STAT_HOLD], 1'b0);
    power_ok <= 1'b0;
    wait_contact(1'b0, 10);
    idle(300);
    see(1'b0, 1'b0, 1'b0);
    power_ok <= 1'b1;
    idle(10);
    see(1'b0, 1'b1, 1'b0);
    give_verdict;
  end
endmodule : tb
`default_nettype wire
